// file: msq_map.vh
// Purpose: Register map, field positions, reset values and timing
//          constants of the multi-step speed and step sequencer block.
// Assumes: 32-bit AXI4-Lite register bus, one aligned word per register.
// Notes:   Definitions only.
`ifndef MSQ_MAP_VH
`define MSQ_MAP_VH

// ==========================================================
// Register byte offsets
`define MSQ_CTRL 8'h00
`define MSQ_FUNC_LO 8'h04
`define MSQ_FUNC_HI 8'h08
`define MSQ_OUTCFG 8'h0c
`define MSQ_DIR 8'h10
`define MSQ_MASTER 8'h14
`define MSQ_ANGLE 8'h18
`define MSQ_GEAR 8'h1c
`define MSQ_DECEL 8'h20
`define MSQ_STATUS 8'h24
`define MSQ_IRQ_STAT 8'h28
`define MSQ_IRQ_MASK 8'h2c
`define MSQ_TRAVEL 8'h30
// Step speed n at 8'h40 + 4*n, step duration n at 8'h80 + 4*n, n 1..15.
`define MSQ_SPEED_REGION 2'b01
`define MSQ_DUR_REGION 2'b10

// ==========================================================
// Control register fields
`define MSQ_CTRL_MODE_LSB 0
`define MSQ_CTRL_UNIT_BIT 4
`define MSQ_CTRL_DEB_LSB 8
`define MSQ_CTRL_RUN_BIT 16
`define MSQ_CTRL_REV_BIT 17

// ==========================================================
// Reset values and limits
`define MSQ_DEB_RESET 5'h01
`define MSQ_DEB_MAX 5'h14
`define MSQ_SPEED_MAX 16'h9c40
`define MSQ_ANGLE_RESET 12'h708
`define MSQ_ANGLE_MAX 12'he10
`define MSQ_GEAR_RESET 10'h0c8
`define MSQ_GEAR_MIN 10'h004
`define MSQ_GEAR_MAX 10'h3e8
`define MSQ_DECEL_MAX 14'h2710

// ==========================================================
// Sequencer modes and terminal function codes
`define MSQ_MODE_OFF 3'h0
`define MSQ_MODE_ONCE 3'h1
`define MSQ_MODE_LOOP 3'h2
`define MSQ_MODE_ONCE_STEP 3'h3
`define MSQ_MODE_LOOP_STEP 3'h4
`define MSQ_FN_SPEED_BIT0 8'h01
`define MSQ_FN_RUN 8'h0e
`define MSQ_FN_PAUSE 8'h0f
`define MSQ_FN_PROX 8'h22
`define MSQ_OUT_RUNNING 8'h0a
`define MSQ_OUT_STEP_DONE 8'h0b
`define MSQ_OUT_PROG_DONE 8'h0c

// ==========================================================
// Timing: all times in microseconds, clock in MHz
`define MSQ_CLK_MHZ 50
`define MSQ_DEB_UNIT_US 2000
`define MSQ_DECEL_UNIT_US 10000
`define MSQ_STEP_UNIT_US 100000
`define MSQ_BASE_CYCLES (`MSQ_DEB_UNIT_US * `MSQ_CLK_MHZ)
`define MSQ_DECEL_TICKS (`MSQ_DECEL_UNIT_US / `MSQ_DEB_UNIT_US)
`define MSQ_STEP_TICKS (`MSQ_STEP_UNIT_US / `MSQ_DEB_UNIT_US)

`endif

// file: msq_debounce.v
// Purpose: Synchronise one input terminal and accept a change only after
//          it has stood for a programmed number of base ticks.
// Assumes: tick is a one-cycle pulse from the same clock.
// Notes:   Delay is units-1 to units ticks after synchronisation.
`timescale 1ns/1ps

module msq_debounce #(
	parameter UNIT_W = 5
) (
	input wire aclk,
	input wire aresetn,
	input wire pin,
	input wire tick,
	input wire [UNIT_W-1:0] units,
	output reg level
);

	reg sync_a;
	reg sync_b;
	reg [UNIT_W-1:0] count;

	always @(posedge aclk) begin
		if (!aresetn) begin
			sync_a <= 1'b0;
			sync_b <= 1'b0;
			count <= {UNIT_W{1'b0}};
			level <= 1'b0;
		end else begin
			sync_a <= pin;
			sync_b <= sync_a;
			if (sync_b == level) begin
				count <= {UNIT_W{1'b0}};
			end else if (tick) begin
				if (count + 1'b1 >= units) begin
					level <= sync_b;
					count <= {UNIT_W{1'b0}};
				end else begin
					count <= count + 1'b1;
				end
			end
		end
	end

endmodule // msq_debounce

// file: msq_sequencer.v
// Purpose: Speed command selection, simple index stop and step sequencer,
//          reached over AXI4-Lite.
// Assumes: Single clock aclk at 50 MHz, synchronous active-low reset.
// Notes:   Ramps and the power stage lie outside this block.
// Contract
// - Four speed-select bits form an index; zero picks the master speed, n picks step speed n.
// - Fifteen step speeds hold 0 to 400.00 Hz in 0.01 Hz units and reset to zero.
// - With the index function active a stop keeps the drive running until the proximity input fires.
// - After the proximity trigger the drive stops using the index angle and index deceleration time; the logic times the stop from the deceleration time alone.
// - The index gear ratio lies between 4 and 1000 and resets to 200.
// - The proximity sensor is only taken from a terminal with function code 34.
// - Sequencer mode 0 is off, 1 one cycle, 2 continuous, 3 one cycle stepwise, 4 continuous stepwise.
// - In one-cycle mode the sequencer stops at the end and restarts only after run drops and returns.
// - In continuous mode cycles repeat until pause (code 15) is set or run (code 14) is removed.
// - The sequencer is started by a terminal with function code 14.
// - Output terminals show running (10), a step-done pulse (11) and program done (12).
// - The program is built from the step speeds, per-step direction and per-step duration.
// - A step with zero duration is skipped.
// - Step direction comes from a 15-bit word; other direction commands are ignored meanwhile.
// - A unit setting selects 1 s (0) or 0.1 s (1) step duration units.
`timescale 1ns/1ps

`include "msq_map.vh"

module msq_sequencer #(
	parameter N_IN = 8,
	parameter N_OUT = 2,
	parameter BASE_CYCLES = `MSQ_BASE_CYCLES
) (
	input wire aclk,
	input wire aresetn,
	input wire [7:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output reg s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output reg s_axi_wready,
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	input wire [7:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output reg s_axi_arready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	input wire [N_IN-1:0] term_in,
	output reg [N_OUT-1:0] term_out,
	output reg [15:0] freq_cmd,
	output reg dir_rev,
	output reg drive_run,
	output reg irq
);

	localparam S_IDLE = 5'b00001;
	localparam S_RUN = 5'b00010;
	localparam S_PAUSE = 5'b00100;
	localparam S_WAIT = 5'b01000;
	localparam S_DONE = 5'b10000;
	localparam D_STOP = 4'b0001;
	localparam D_RUN = 4'b0010;
	localparam D_HOLD = 4'b0100;
	localparam D_DECEL = 4'b1000;

	// ==========================================================
	// Registers
	reg [2:0] mode;
	reg unit_tenth;
	reg [4:0] deb_units;
	reg sw_run;
	reg sw_rev;
	reg [8*N_IN-1:0] func;
	reg [8*N_OUT-1:0] outcfg;
	reg [14:0] step_dir;
	reg [15:0] master;
	reg [11:0] angle;
	reg [9:0] gear;
	reg [13:0] decel;
	reg [3:0] irq_stat;
	reg [3:0] irq_mask;
	reg [21:0] travel;
	reg [15:0] speed [1:15];
	reg [15:0] dur [1:15];

	// ==========================================================
	// Time base
	reg [31:0] base_cnt;
	reg base_tick;
	reg [2:0] dec_pre;
	reg dec_tick;

	always @(posedge aclk) begin
		if (!aresetn) begin
			base_cnt <= 32'h0;
			base_tick <= 1'b0;
			dec_pre <= 3'h0;
			dec_tick <= 1'b0;
		end else begin
			base_tick <= (base_cnt == BASE_CYCLES - 1);
			base_cnt <= (base_cnt == BASE_CYCLES - 1) ? 32'h0 :
				base_cnt + 32'h1;
			dec_tick <= 1'b0;
			if (base_tick) begin
				dec_tick <= (dec_pre == `MSQ_DECEL_TICKS - 1);
				dec_pre <= (dec_pre == `MSQ_DECEL_TICKS - 1) ? 3'h0 :
					dec_pre + 3'h1;
			end
		end
	end

	// ==========================================================
	// Input terminals and function decode
	wire [N_IN-1:0] term_lvl;
	genvar g;
	generate
		for (g = 0; g < N_IN; g = g + 1) begin : deb
			msq_debounce #(.UNIT_W(5)) u_deb (
				.aclk(aclk),
				.aresetn(aresetn),
				.pin(term_in[g]),
				.tick(base_tick),
				.units(deb_units),
				.level(term_lvl[g])
			);
		end
	endgenerate

	reg [3:0] sel;
	reg run_in;
	reg pause_in;
	reg prox_in;
	reg prox_en;
	integer i;
	integer j;
	integer k;
	integer m;
	always @* begin
		sel = 4'h0;
		run_in = 1'b0;
		pause_in = 1'b0;
		prox_in = 1'b0;
		prox_en = 1'b0;
		for (i = 0; i < N_IN; i = i + 1) begin
			if (func[8*i+:8] == `MSQ_FN_SPEED_BIT0)
				sel[0] = sel[0] | term_lvl[i];
			if (func[8*i+:8] == `MSQ_FN_SPEED_BIT0 + 8'h1)
				sel[1] = sel[1] | term_lvl[i];
			if (func[8*i+:8] == `MSQ_FN_SPEED_BIT0 + 8'h2)
				sel[2] = sel[2] | term_lvl[i];
			if (func[8*i+:8] == `MSQ_FN_SPEED_BIT0 + 8'h3)
				sel[3] = sel[3] | term_lvl[i];
			if (func[8*i+:8] == `MSQ_FN_RUN)
				run_in = run_in | term_lvl[i];
			if (func[8*i+:8] == `MSQ_FN_PAUSE)
				pause_in = pause_in | term_lvl[i];
			if (func[8*i+:8] == `MSQ_FN_PROX) begin
				prox_in = prox_in | term_lvl[i];
				prox_en = 1'b1;
			end
		end
	end

	// ==========================================================
	// Next non-skipped step after cur (0 searches from the first)
	reg [4:0] seq_state;
	reg [3:0] step;
	reg [19:0] remain;
	reg [3:0] nxt;
	reg [3:0] first;
	always @* begin
		nxt = 4'h0;
		first = 4'h0;
		for (j = 15; j >= 1; j = j - 1) begin
			if (dur[j] != 16'h0) begin
				first = j[3:0];
				if (j[3:0] > step)
					nxt = j[3:0];
			end
		end
	end

	wire [19:0] dur_load_n = unit_tenth ? {4'h0, dur[nxt]} :
		{1'b0, dur[nxt], 3'b0} + {3'b0, dur[nxt], 1'b0};
	wire [19:0] dur_load_f = unit_tenth ? {4'h0, dur[first]} :
		{1'b0, dur[first], 3'b0} + {3'b0, dur[first], 1'b0};
	wire stepwise = (mode == `MSQ_MODE_ONCE_STEP) ||
		(mode == `MSQ_MODE_LOOP_STEP);
	wire looping = (mode == `MSQ_MODE_LOOP) ||
		(mode == `MSQ_MODE_LOOP_STEP);
	wire mode_ok = (mode != `MSQ_MODE_OFF) && (mode <= `MSQ_MODE_LOOP_STEP);

	// ==========================================================
	// Step sequencer
	reg pause_d;
	reg step_pulse;
	reg cycle_pulse;
	// The step prescaler restarts with every step, so a step never ends
	// early on a free-running tick; a pause freezes it where it stands.
	reg [5:0] step_pre;
	wire step_due = base_tick && (step_pre == `MSQ_STEP_TICKS - 1);
	always @(posedge aclk) begin
		if (!aresetn) begin
			seq_state <= S_IDLE;
			step <= 4'h0;
			remain <= 20'h0;
			pause_d <= 1'b0;
			step_pre <= 6'h0;
			step_pulse <= 1'b0;
			cycle_pulse <= 1'b0;
		end else begin
			pause_d <= pause_in;
			step_pulse <= 1'b0;
			cycle_pulse <= 1'b0;
			case (seq_state)
			S_IDLE: begin
				step <= 4'h0;
				step_pre <= 6'h0;
				if (mode_ok && run_in) begin
					if (first == 4'h0) begin
						cycle_pulse <= 1'b1;
						seq_state <= S_DONE;
					end else begin
						step <= first;
						remain <= dur_load_f;
						seq_state <= S_RUN;
					end
				end
			end
			S_RUN: begin
				if (!run_in || !mode_ok) begin
					seq_state <= S_IDLE;
				end else if (pause_in) begin
					seq_state <= S_PAUSE;
				end else if (base_tick && !step_due) begin
					step_pre <= step_pre + 6'h1;
				end else if (step_due) begin
					step_pre <= 6'h0;
					if (remain > 20'h1) begin
						remain <= remain - 20'h1;
					end else begin
						step_pulse <= 1'b1;
						if (nxt == 4'h0)
							cycle_pulse <= 1'b1;
						if (stepwise) begin
							seq_state <= S_WAIT;
						end else if (nxt != 4'h0) begin
							step <= nxt;
							remain <= dur_load_n;
						end else if (looping && first != 4'h0) begin
							step <= first;
							remain <= dur_load_f;
						end else begin
							seq_state <= S_DONE;
						end
					end
				end
			end
			S_PAUSE: begin
				if (!run_in || !mode_ok)
					seq_state <= S_IDLE;
				else if (!pause_in)
					seq_state <= S_RUN;
			end
			S_WAIT: begin
				// A press and release of pause releases the next step.
				if (!run_in || !mode_ok) begin
					seq_state <= S_IDLE;
				end else if (pause_d && !pause_in) begin
					step_pre <= 6'h0;
					if (nxt != 4'h0) begin
						step <= nxt;
						remain <= dur_load_n;
						seq_state <= S_RUN;
					end else if (looping && first != 4'h0) begin
						step <= first;
						remain <= dur_load_f;
						seq_state <= S_RUN;
					end else begin
						seq_state <= S_DONE;
					end
				end
			end
			S_DONE: begin
				if (!run_in)
					seq_state <= S_IDLE;
			end
			default: seq_state <= S_IDLE;
			endcase
		end
	end

	wire seq_active = (seq_state == S_RUN) || (seq_state == S_PAUSE) ||
		(seq_state == S_WAIT);

	// ==========================================================
	// Drive run state with simple index stop
	reg [3:0] drv_state;
	reg [13:0] dec_cnt;
	reg prox_d;
	reg prox_event;
	reg stop_event;
	wire run_req = sw_run | seq_active;
	always @(posedge aclk) begin
		if (!aresetn) begin
			drv_state <= D_STOP;
			dec_cnt <= 14'h0;
			prox_d <= 1'b0;
			prox_event <= 1'b0;
			stop_event <= 1'b0;
		end else begin
			prox_d <= prox_in;
			prox_event <= 1'b0;
			stop_event <= 1'b0;
			case (drv_state)
			D_STOP: if (run_req) drv_state <= D_RUN;
			D_RUN: begin
				if (!run_req)
					drv_state <= prox_en ? D_HOLD : D_STOP;
			end
			D_HOLD: begin
				if (run_req) begin
					drv_state <= D_RUN;
				end else if (prox_in && !prox_d) begin
					prox_event <= 1'b1;
					dec_cnt <= decel;
					if (decel == 14'h0) begin
						stop_event <= 1'b1;
						drv_state <= D_STOP;
					end else begin
						drv_state <= D_DECEL;
					end
				end
			end
			D_DECEL: begin
				if (dec_tick) begin
					if (dec_cnt == 14'h1) begin
						stop_event <= 1'b1;
						drv_state <= D_STOP;
					end
					dec_cnt <= dec_cnt - 14'h1;
				end
			end
			default: drv_state <= D_STOP;
			endcase
		end
	end

	// ==========================================================
	// Outputs
	reg [N_OUT-1:0] next_term_out;
	always @* begin
		next_term_out = {N_OUT{1'b0}};
		for (k = 0; k < N_OUT; k = k + 1) begin
			case (outcfg[8*k+:8])
			`MSQ_OUT_RUNNING: next_term_out[k] = seq_active;
			`MSQ_OUT_STEP_DONE: next_term_out[k] = step_pulse;
			`MSQ_OUT_PROG_DONE:
				next_term_out[k] = cycle_pulse | (seq_state == S_DONE);
			default: next_term_out[k] = 1'b0;
			endcase
		end
	end

	always @(posedge aclk) begin
		if (!aresetn) begin
			term_out <= {N_OUT{1'b0}};
			freq_cmd <= 16'h0;
			dir_rev <= 1'b0;
			drive_run <= 1'b0;
			irq <= 1'b0;
			travel <= 22'h0;
		end else begin
			term_out <= next_term_out;
			drive_run <= (drv_state != D_STOP);
			irq <= |(irq_stat & irq_mask);
			travel <= {10'h0, angle} * {12'h0, gear};
			if (seq_active) begin
				freq_cmd <= (seq_state == S_WAIT) ? 16'h0 : speed[step];
				dir_rev <= step_dir[step - 4'h1];
			end else if (drv_state == D_STOP) begin
				freq_cmd <= 16'h0;
				dir_rev <= sw_rev;
			end else if (drv_state == D_RUN) begin
				freq_cmd <= (sel == 4'h0) ? master : speed[sel];
				dir_rev <= sw_rev;
			end
		end
	end

	// ==========================================================
	// AXI4-Lite slave
	reg aw_have;
	reg w_have;
	reg [7:0] aw_addr;
	reg [31:0] w_data;
	reg [3:0] w_strb;
	reg rd_stat;
	wire [31:0] wd = w_data;
	wire do_wr = aw_have && w_have && !s_axi_bvalid;
	wire [3:0] widx = aw_addr[5:2];
	wire [4:0] deb_w = (wd[12:8] == 5'h0) ? 5'h1 :
		(wd[12:8] > `MSQ_DEB_MAX) ? `MSQ_DEB_MAX : wd[12:8];
	wire [9:0] gear_w = (wd[9:0] < `MSQ_GEAR_MIN) ? `MSQ_GEAR_MIN :
		(wd[9:0] > `MSQ_GEAR_MAX) ? `MSQ_GEAR_MAX : wd[9:0];

	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= 2'b00;
			aw_have <= 1'b0;
			w_have <= 1'b0;
			aw_addr <= 8'h0;
			w_data <= 32'h0;
			w_strb <= 4'h0;
			mode <= `MSQ_MODE_OFF;
			unit_tenth <= 1'b0;
			deb_units <= `MSQ_DEB_RESET;
			sw_run <= 1'b0;
			sw_rev <= 1'b0;
			func <= {8*N_IN{1'b0}};
			outcfg <= {8*N_OUT{1'b0}};
			step_dir <= 15'h0;
			master <= 16'h0;
			angle <= `MSQ_ANGLE_RESET;
			gear <= `MSQ_GEAR_RESET;
			decel <= 14'h0;
			irq_mask <= 4'h0;
			for (m = 1; m <= 15; m = m + 1) begin
				speed[m] <= 16'h0;
				dur[m] <= 16'h0;
			end
		end else begin
			s_axi_awready <= !aw_have && !s_axi_awready && s_axi_awvalid;
			s_axi_wready <= !w_have && !s_axi_wready && s_axi_wvalid;
			if (s_axi_awvalid && s_axi_awready) begin
				aw_have <= 1'b1;
				aw_addr <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_have <= 1'b1;
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
			end
			if (s_axi_bvalid && s_axi_bready)
				s_axi_bvalid <= 1'b0;
			if (do_wr) begin
				aw_have <= 1'b0;
				w_have <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= 2'b00;
				// Registers update only on a full-word write.
				if (w_strb == 4'hf) begin
					case (aw_addr)
					`MSQ_CTRL: begin
						mode <= wd[`MSQ_CTRL_MODE_LSB+:3];
						unit_tenth <= wd[`MSQ_CTRL_UNIT_BIT];
						deb_units <= deb_w;
						sw_run <= wd[`MSQ_CTRL_RUN_BIT];
						sw_rev <= wd[`MSQ_CTRL_REV_BIT];
					end
					`MSQ_FUNC_LO: func[31:0] <= wd;
					`MSQ_FUNC_HI: func[8*N_IN-1:32] <= wd[8*N_IN-33:0];
					`MSQ_OUTCFG: outcfg <= wd[8*N_OUT-1:0];
					`MSQ_DIR: step_dir <= wd[14:0];
					`MSQ_MASTER: master <= (wd[15:0] > `MSQ_SPEED_MAX) ?
						`MSQ_SPEED_MAX : wd[15:0];
					`MSQ_ANGLE: angle <= (wd[11:0] > `MSQ_ANGLE_MAX) ?
						`MSQ_ANGLE_MAX : wd[11:0];
					`MSQ_GEAR: gear <= gear_w;
					`MSQ_DECEL: decel <= (wd[13:0] > `MSQ_DECEL_MAX) ?
						`MSQ_DECEL_MAX : wd[13:0];
					`MSQ_IRQ_MASK: irq_mask <= wd[3:0];
					default: begin
						if (aw_addr[7:6] == `MSQ_SPEED_REGION && widx != 4'h0)
							speed[widx] <= (wd[15:0] > `MSQ_SPEED_MAX) ?
								`MSQ_SPEED_MAX : wd[15:0];
						if (aw_addr[7:6] == `MSQ_DUR_REGION && widx != 4'h0)
							dur[widx] <= wd[15:0];
					end
					endcase
				end
			end
		end
	end

	// Read side; an event in the read handshake cycle is lost to the clear, one a cycle later survives.
	wire [3:0] events = {stop_event, prox_event, cycle_pulse, step_pulse};
	wire [3:0] ridx = s_axi_araddr[5:2];
	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0;
			s_axi_rresp <= 2'b00;
			irq_stat <= 4'h0;
			rd_stat <= 1'b0;
		end else begin
			s_axi_arready <= !s_axi_rvalid && !s_axi_arready &&
				s_axi_arvalid;
			rd_stat <= 1'b0;
			irq_stat <= (rd_stat ? 4'h0 : irq_stat) | events;
			if (s_axi_rvalid && s_axi_rready)
				s_axi_rvalid <= 1'b0;
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp <= 2'b00;
				s_axi_rdata <= 32'h0;
				case (s_axi_araddr)
				`MSQ_CTRL: s_axi_rdata <= {14'h0, sw_rev, sw_run, 3'h0,
					deb_units, 3'h0, unit_tenth, 1'b0, mode};
				`MSQ_FUNC_LO: s_axi_rdata <= func[31:0];
				`MSQ_FUNC_HI: s_axi_rdata[8*N_IN-33:0] <= func[8*N_IN-1:32];
				`MSQ_OUTCFG: s_axi_rdata[8*N_OUT-1:0] <= outcfg;
				`MSQ_DIR: s_axi_rdata[14:0] <= step_dir;
				`MSQ_MASTER: s_axi_rdata[15:0] <= master;
				`MSQ_ANGLE: s_axi_rdata[11:0] <= angle;
				`MSQ_GEAR: s_axi_rdata[9:0] <= gear;
				`MSQ_DECEL: s_axi_rdata[13:0] <= decel;
				`MSQ_STATUS: s_axi_rdata <= {7'h0, drv_state, seq_state,
					sel, step, term_lvl};
				`MSQ_IRQ_STAT: begin
					s_axi_rdata[3:0] <= irq_stat;
					rd_stat <= 1'b1;
				end
				`MSQ_IRQ_MASK: s_axi_rdata[3:0] <= irq_mask;
				`MSQ_TRAVEL: s_axi_rdata[21:0] <= travel;
				default: begin
					if (s_axi_araddr[7:6] == `MSQ_SPEED_REGION && ridx != 4'h0)
						s_axi_rdata[15:0] <= speed[ridx];
					if (s_axi_araddr[7:6] == `MSQ_DUR_REGION && ridx != 4'h0)
						s_axi_rdata[15:0] <= dur[ridx];
				end
				endcase
			end
		end
	end

endmodule // msq_sequencer

// file: msq_seq_sva.sv
// Purpose: Concurrent checks on the ports of the sequencer block.
// Assumes: Output terminal 1 carries the step-done code whenever it is used.
// Notes:   Bound to every instance of the block.
`timescale 1ns/1ps

module msq_seq_sva #(
	parameter N_OUT = 2
) (
	input wire aclk,
	input wire aresetn,
	input wire s_axi_awvalid,
	input wire s_axi_awready,
	input wire s_axi_wvalid,
	input wire s_axi_wready,
	input wire s_axi_bvalid,
	input wire s_axi_bready,
	input wire [1:0] s_axi_bresp,
	input wire s_axi_arvalid,
	input wire s_axi_arready,
	input wire s_axi_rvalid,
	input wire s_axi_rready,
	input wire [31:0] s_axi_rdata,
	input wire [N_OUT-1:0] term_out,
	input wire [15:0] freq_cmd,
	input wire drive_run
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	sequence both_taken;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence read_taken;
		s_axi_arvalid && s_axi_arready;
	endsequence
	a_write_answer: assert property (both_taken |-> ##[1:3] s_axi_bvalid)
		else $error("write got no response");
	a_bvalid_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
		else $error("write response dropped early");
	a_okay_resp: assert property (s_axi_bvalid |-> s_axi_bresp == 2'b00)
		else $error("write response not okay");
	a_read_answer: assert property (read_taken |=> s_axi_rvalid)
		else $error("read data late");
	a_rdata_stable: assert property (s_axi_rvalid && !s_axi_rready |=>
		s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data changed while waiting");
	a_aw_pulse: assert property (s_axi_awready |=> !s_axi_awready)
		else $error("address ready longer than one cycle");
	a_quiet_reset: assert property (disable iff (1'b0) !aresetn |=>
		freq_cmd == 16'h0 && !drive_run)
		else $error("outputs active in reset");
	a_speed_limit: assert property (freq_cmd <= 16'h9c40)
		else $error("frequency above ceiling");
	a_step_pulse: assert property (term_out[1] |=> !term_out[1])
		else $error("step done longer than one cycle");
endmodule // msq_seq_sva

bind msq_sequencer msq_seq_sva #(.N_OUT(N_OUT)) chk_u (
	.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
	.s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
	.s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready,
	.s_axi_rdata, .term_out, .freq_cmd, .drive_run
);

// file: msq_switches.sv
// Purpose: Switches, buttons and proximity sensor on the input terminals.
// Assumes: Contacts are sampled on the block clock.
// Notes:   Every change chatters once, so debounce is exercised.
`timescale 1ns/1ps

module msq_switches (
	input wire aclk,
	input wire [7:0] want,
	output reg [7:0] term_in
);
	reg [7:0] a = 8'h00;
	reg [7:0] b = 8'h00;
	initial term_in = 8'h00;
	// A new level shows, falls back for one cycle, then settles.
	always @(posedge aclk) begin
		a <= want;
		b <= a;
		if (want != a)
			term_in <= want;
		else if (a != b)
			term_in <= b;
		else
			term_in <= a;
	end
endmodule // msq_switches

// file: msq_sequencer_tb_top.sv
// Purpose: Self-checking bench for the speed selector and step sequencer.
// Assumes: BASE_CYCLES of 10, so one 0.1 s step unit is 500 clocks.
// Notes:   Read data and output snapshots are checked from one queue.
`timescale 1ns/1ps
`include "msq_map.vh"

module msq_sequencer_tb_top;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, want = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, take = 1'b0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	logic s_axi_rvalid, dir_rev, drive_run, irq;
	logic [1:0] s_axi_bresp, s_axi_rresp, term_out;
	logic [31:0] s_axi_rdata;
	logic [7:0] term_in;
	logic [15:0] freq_cmd;
	logic [31:0] exp_q[$];
	logic [15:0] spd[16];
	int num_errors = 0, num_checks = 0, cyc = 0;
	wire [3:0] flags = {~drive_run, irq, term_out};
	wire [31:0] outs = {14'h0, irq, dir_rev, freq_cmd};

	msq_sequencer #(.BASE_CYCLES(10)) dut_u (
		.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready,
		.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
		.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready, .term_in, .term_out, .freq_cmd,
		.dir_rev, .drive_run, .irq
	);
	msq_switches sw_u (.aclk, .want, .term_in);

	always #10 aclk = ~aclk;

	// ==========================================================
	// Checking and closing
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("BAD t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic give_verdict;
		$display("checks %0d errors %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	always @(posedge aclk) begin
		cyc <= cyc + 1;
		if (cyc == 30000) begin
			num_errors++;
			give_verdict();
		end
	end

	always @(posedge aclk) begin
		if (s_axi_rvalid && s_axi_rready)
			check(s_axi_rdata, exp_q.pop_front());
		if (take)
			check(outs, exp_q.pop_front());
	end

	// ==========================================================
	// Bus and terminal tasks
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wready)
				s_axi_wvalid <= 1'b0;
		end while (s_axi_bvalid !== 1'b1);
		s_axi_bready <= 1'b0;
		@(posedge aclk);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		exp_q.push_back(e);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_arready)
				s_axi_arvalid <= 1'b0;
		end while (s_axi_rvalid !== 1'b1);
		s_axi_rready <= 1'b0;
		@(posedge aclk);
	endtask

	task automatic snap(input logic [31:0] e);
		exp_q.push_back(e);
		take <= 1'b1;
		@(posedge aclk);
		take <= 1'b0;
	endtask

	// Bounded wait for one of the flags; a timeout shows as a mismatch.
	task automatic await(input int k, input int lim);
		int n;
		for (n = 0; n < lim && flags[k] !== 1'b1; n++)
			@(posedge aclk);
		check({31'h0, flags[k]}, 32'h1);
	endtask

	// ==========================================================
	// Main sequence
	initial begin
		int i;
		void'($urandom(32'h3ef6d827));
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		rd(`MSQ_GEAR, 32'd200);
		rd(`MSQ_ANGLE, 32'd1800);
		rd(`MSQ_CTRL, 32'h100);
		rd(8'h44, 32'h0);
		rd(8'h3c, 32'h0);
		wr(`MSQ_GEAR, 32'd2);
		rd(`MSQ_GEAR, 32'd4);
		wr(8'h44, 32'd50000);
		rd(8'h44, 32'h9c40);
		wr(`MSQ_FUNC_LO, 32'h04030201);
		wr(`MSQ_CTRL, 32'h10100);
		for (i = 0; i < 16; i++) begin
			spd[i] = 16'($urandom % 40001);
			wr(i ? 8'h40 + 8'(4 * i) : `MSQ_MASTER, {16'h0, spd[i]});
		end
		for (i = 0; i < 16; i++) begin
			want[3:0] <= 4'(i);
			repeat (40) @(posedge aclk);
			snap({16'h0, spd[i]});
		end
		want <= 8'h00;
		wr(`MSQ_CTRL, 32'h111);
		wr(`MSQ_FUNC_HI, 32'h0f0e);
		wr(`MSQ_OUTCFG, 32'h0b0a);
		wr(`MSQ_DIR, 32'h1);
		wr(`MSQ_IRQ_MASK, 32'h2);
		wr(8'h84, 32'h1);
		wr(8'h88, 32'h0);
		wr(8'h8c, 32'h2);
		want[4] <= 1'b1;
		await(0, 100);
		repeat (250) @(posedge aclk);
		snap({16'h1, spd[1]});
		await(1, 400);
		repeat (250) @(posedge aclk);
		snap({16'h0, spd[3]});
		await(2, 1200);
		rd(`MSQ_IRQ_STAT, 32'h3);
		repeat (3) @(posedge aclk);
		check({31'h0, irq}, 32'h0);
		repeat (600) @(posedge aclk);
		check({30'h0, term_out}, 32'h0);
		want[4] <= 1'b0;
		repeat (40) @(posedge aclk);
		want[4] <= 1'b1;
		await(0, 100);
		want[4] <= 1'b0;
		wr(`MSQ_FUNC_HI, 32'h220f0e);
		wr(`MSQ_CTRL, 32'h10100);
		want[3:0] <= 4'h1;
		repeat (40) @(posedge aclk);
		wr(`MSQ_CTRL, 32'h100);
		repeat (100) @(posedge aclk);
		check({31'h0, drive_run}, 32'h1);
		want[6] <= 1'b1;
		await(3, 60);
		wr(`MSQ_CTRL, 32'h112);
		want[4] <= 1'b1;
		await(0, 100);
		repeat (1750) @(posedge aclk);
		snap({16'h3, spd[1]});
		wr(`MSQ_CTRL, 32'h114);
		repeat (400) @(posedge aclk);
		snap({16'h3, 16'h0});
		want[5] <= 1'b1;
		repeat (40) @(posedge aclk);
		want[5] <= 1'b0;
		repeat (40) @(posedge aclk);
		snap({16'h2, spd[3]});
		give_verdict();
	end
endmodule // msq_sequencer_tb_top
